// ==== verilog/bmc_ctrl.sv ====
// Button operating mode controller: mode FSM, beeper, LEDs, storage.
// Assumes tick_i is a one-cycle pulse every TICK_MS from clk_i logic;
// buttons are raw pins, all other inputs come from clk_i logic.
`timescale 1ns/100ps

module bmc_ctrl
  import bmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic btn_upper_i,
  input wire logic btn_lower_i,
  input wire logic login_i,
  input wire logic fn_good_i,
  input wire logic fn_fail_i,
  input wire logic mute_i,
  input wire logic vol_low_i,
  input wire logic save_req_i,
  input wire logic load_req_i,
  input wire logic card_present_i,
  input wire logic ext_present_i,
  output logic btn_mode_o,
  output logic read_halt_o,
  output logic trig_en_o,
  output logic host_out_en_o,
  output logic status_blank_o,
  output logic [3:0] fn_led_o,
  output logic [1:0] fn_sel_o,
  output logic fn_run_o,
  output logic ready_grn_o,
  output logic ready_red_o,
  output logic beep_o,
  output logic [1:0] beep_pitch_o,
  output logic beep_en_o,
  output logic beep_full_o,
  output logic nvs_wr_o,
  output logic card_wr_o,
  output logic load_go_o,
  output logic [1:0] load_src_o
);

  // ************************************************************
  // Buttons
  // ************************************************************
  bmc_btn_if up_if();
  bmc_btn_if lo_if();

  bmc_button u_up
  (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .tick_i(tick_i),
    .btn_i(btn_upper_i),
    .ev(up_if)
  );

  bmc_button u_lo
  (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .tick_i(tick_i),
    .btn_i(btn_lower_i),
    .ev(lo_if)
  );

  // ************************************************************
  // Mode state machine
  // ************************************************************
  bmc_state_t state_ff, nxt_state;
  logic [1:0] sel_ff, nxt_sel;
  logic [15:0] idle_ff, nxt_idle, run_ff, nxt_run;
  logic mel_go, flash_go, flash_red;
  bmc_mel_t mel_sel;
  logic auto_fn;

  assign auto_fn = (sel_ff == FN_LEARN) || (sel_ff == FN_SETUP);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_sel = sel_ff;
    nxt_idle = idle_ff;
    nxt_run = run_ff;
    mel_go = 1'b0;
    mel_sel = MEL_ONE;
    flash_go = 1'b0;
    flash_red = 1'b0;
    case (state_ff)
      ST_READ:
      begin
        nxt_idle = 16'h0;
        nxt_run = 16'h0;
        if (up_if.long_p)
        begin
          mel_go = 1'b1;
          if (login_i)
          begin
            mel_sel = MEL_FALL;
          end
          else
          begin
            nxt_state = ST_SEL;
            nxt_sel = FN_DIAG;
            mel_sel = MEL_RISE;
          end
        end
      end
      ST_SEL:
      begin
        if (tick_i)
        begin
          nxt_idle = idle_ff + 16'h1;
        end
        if (up_if.press_p || lo_if.press_p)
        begin
          nxt_idle = 16'h0;
        end
        if (login_i || up_if.long_p ||
            (tick_i && idle_ff == IDLE_TICKS - 16'h1))
        begin
          nxt_state = ST_READ;
          mel_go = 1'b1;
          mel_sel = MEL_FALL;
        end
        else if (up_if.short_p)
        begin
          nxt_state = ST_RUN;
          nxt_run = 16'h0;
          mel_go = 1'b1;
          mel_sel = MEL_TWO;
        end
        else if (lo_if.press_p)
        begin
          nxt_sel = sel_ff + 2'h1;
          mel_go = 1'b1;
          mel_sel = MEL_ONE;
        end
      end
      ST_RUN:
      begin
        nxt_idle = 16'h0;
        if (tick_i)
        begin
          nxt_run = run_ff + 16'h1;
        end
        if (login_i || up_if.long_p ||
            (tick_i && run_ff == RUN_TICKS - 16'h1))
        begin
          nxt_state = ST_READ;
          mel_go = 1'b1;
          mel_sel = MEL_FALL;
        end
        else if (up_if.short_p)
        begin
          nxt_state = ST_SEL;
          mel_go = 1'b1;
          mel_sel = MEL_TWO;
        end
        else if (auto_fn && fn_good_i)
        begin
          nxt_state = ST_SEL;
          flash_go = 1'b1;
          mel_go = 1'b1;
          mel_sel = MEL_RISE;
        end
        else if (auto_fn && fn_fail_i)
        begin
          nxt_state = ST_SEL;
          flash_go = 1'b1;
          flash_red = 1'b1;
          mel_go = 1'b1;
          mel_sel = MEL_FALL;
        end
      end
      default:
      begin
        nxt_state = ST_READ;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      state_ff <= ST_READ;
      sel_ff <= FN_DIAG;
      idle_ff <= 16'h0;
      run_ff <= 16'h0;
    end
    else if (ce_i)
    begin
      state_ff <= nxt_state;
      sel_ff <= nxt_sel;
      idle_ff <= nxt_idle;
      run_ff <= nxt_run;
    end
  end

  // ************************************************************
  // Melody sequencer, ready flash and blink base
  // ************************************************************
  bmc_mel_t mkind_ff, nxt_mkind;
  logic [1:0] slot_ff, nxt_slot;
  logic [7:0] tcnt_ff, nxt_tcnt;
  logic mbusy_ff, nxt_mbusy;
  logic [2:0] fleft_ff, nxt_fleft;
  logic [7:0] fcnt_ff, nxt_fcnt;
  logic fred_ff, nxt_fred;
  logic [7:0] blink_ff, nxt_blink;

  // Tone on, pitch for one slot of a melody
  function automatic logic [2:0] mel_pat(bmc_mel_t k, logic [1:0] s);
    case (k)
      MEL_ONE: mel_pat = (s == 2'h0) ? 3'h5 : 3'h0;
      MEL_TWO: mel_pat = (s == 2'h0 || s == 2'h2) ? 3'h5 : 3'h0;
      MEL_RISE: mel_pat = (s == 2'h3) ? 3'h0 : {1'b1, s};
      MEL_FALL: mel_pat = (s == 2'h3) ? 3'h0 : {1'b1, 2'h2 - s};
      default: mel_pat = 3'h0;
    endcase
  endfunction

  always_comb
  begin
    nxt_mkind = mkind_ff;
    nxt_slot = slot_ff;
    nxt_tcnt = tcnt_ff;
    nxt_mbusy = mbusy_ff;
    nxt_fleft = fleft_ff;
    nxt_fcnt = fcnt_ff;
    nxt_fred = fred_ff;
    nxt_blink = tick_i ? blink_ff + 8'h1 : blink_ff;
    if (mel_go)
    begin
      nxt_mkind = mel_sel;
      nxt_slot = 2'h0;
      nxt_tcnt = 8'h0;
      nxt_mbusy = 1'b1;
    end
    else if (mbusy_ff && tick_i)
    begin
      nxt_tcnt = tcnt_ff + 8'h1;
      if (tcnt_ff == TONE_TICKS - 8'h1)
      begin
        nxt_tcnt = 8'h0;
        nxt_slot = slot_ff + 2'h1;
        nxt_mbusy = (slot_ff != MEL_LAST_SLOT);
      end
    end
    if (flash_go)
    begin
      nxt_fleft = FLASH_HALVES;
      nxt_fcnt = 8'h0;
      nxt_fred = flash_red;
    end
    else if (fleft_ff != 3'h0 && tick_i)
    begin
      nxt_fcnt = fcnt_ff + 8'h1;
      if (fcnt_ff == FLASH_TICKS - 8'h1)
      begin
        nxt_fcnt = 8'h0;
        nxt_fleft = fleft_ff - 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      mkind_ff <= MEL_ONE;
      slot_ff <= 2'h0;
      tcnt_ff <= 8'h0;
      mbusy_ff <= 1'b0;
      fleft_ff <= 3'h0;
      fcnt_ff <= 8'h0;
      fred_ff <= 1'b0;
      blink_ff <= 8'h0;
    end
    else if (ce_i)
    begin
      mkind_ff <= nxt_mkind;
      slot_ff <= nxt_slot;
      tcnt_ff <= nxt_tcnt;
      mbusy_ff <= nxt_mbusy;
      fleft_ff <= nxt_fleft;
      fcnt_ff <= nxt_fcnt;
      fred_ff <= nxt_fred;
      blink_ff <= nxt_blink;
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  logic in_mode, flash_on, blink, benable;
  logic [2:0] pat;
  logic [3:0] nxt_fn_led;
  logic [1:0] nxt_load_src;

  always_comb
  begin
    in_mode = (state_ff != ST_READ);
    flash_on = (fleft_ff != 3'h0) && !fleft_ff[0];
    blink = (state_ff == ST_RUN) ? blink_ff[FAST_BIT] : blink_ff[SLOW_BIT];
    nxt_fn_led = in_mode ? (4'h1 << sel_ff) & {4{blink}} : 4'h0;
    benable = in_mode || !mute_i;
    pat = mel_pat(mkind_ff, slot_ff);
    nxt_load_src = load_src_o;
    if (load_req_i)
    begin
      if (ext_present_i)
        nxt_load_src = SRC_EXT;
      else if (card_present_i)
        nxt_load_src = SRC_CARD;
      else
        nxt_load_src = SRC_INT;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      btn_mode_o <= 1'b0;
      read_halt_o <= 1'b0;
      trig_en_o <= 1'b1;
      host_out_en_o <= 1'b1;
      status_blank_o <= 1'b0;
      fn_led_o <= 4'h0;
      fn_sel_o <= FN_DIAG;
      fn_run_o <= 1'b0;
      ready_grn_o <= 1'b1;
      ready_red_o <= 1'b0;
      beep_o <= 1'b0;
      beep_pitch_o <= 2'h0;
      beep_en_o <= 1'b1;
      beep_full_o <= 1'b1;
      nvs_wr_o <= 1'b0;
      card_wr_o <= 1'b0;
      load_go_o <= 1'b0;
      load_src_o <= SRC_INT;
    end
    else if (ce_i)
    begin
      btn_mode_o <= in_mode;
      read_halt_o <= in_mode;
      trig_en_o <= !in_mode;
      host_out_en_o <= !in_mode;
      status_blank_o <= in_mode;
      fn_led_o <= nxt_fn_led;
      fn_sel_o <= sel_ff;
      fn_run_o <= (state_ff == ST_RUN);
      ready_grn_o <= in_mode ? flash_on && !fred_ff : 1'b1;
      ready_red_o <= in_mode && flash_on && fred_ff;
      beep_o <= mbusy_ff && pat[2] && benable;
      beep_pitch_o <= pat[1:0];
      beep_en_o <= benable;
      beep_full_o <= in_mode || !vol_low_i;
      nvs_wr_o <= save_req_i;
      card_wr_o <= save_req_i && card_present_i;
      load_go_o <= load_req_i;
      load_src_o <= nxt_load_src;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  mode_entry_a: assert property (
    state_ff == ST_READ && up_if.long_p && !login_i && ce_i
    |=> state_ff == ST_SEL && sel_ff == FN_DIAG && mkind_ff == MEL_RISE
    ##1 ce_i [*1] |=> status_blank_o && read_halt_o)
    else $error("Long press did not enter button mode");

  trig_block_a: assert property (
    state_ff != ST_READ && ce_i |=> !trig_en_o && !host_out_en_o)
    else $error("Trigger or host output open in button mode");

  sel_wrap_a: assert property (
    state_ff == ST_SEL && lo_if.press_p && !up_if.long_p &&
    !up_if.short_p && !login_i && ce_i && !tick_i
    |=> sel_ff == $past(sel_ff) + 2'h1 && mkind_ff == MEL_ONE && mbusy_ff)
    else $error("Lower press did not step with one tone");

  fn_start_a: assert property (
    state_ff == ST_SEL && up_if.short_p && !up_if.long_p &&
    !login_i && !tick_i && ce_i
    |=> state_ff == ST_RUN && mkind_ff == MEL_TWO)
    else $error("Short press did not start function");

  fn_stop_a: assert property (
    state_ff == ST_RUN && up_if.short_p && !up_if.long_p &&
    !login_i && !tick_i && ce_i
    |=> state_ff == ST_SEL && mkind_ff == MEL_TWO)
    else $error("Short press did not stop function");

  fail_stay_a: assert property (
    state_ff == ST_RUN && auto_fn && fn_fail_i && !fn_good_i &&
    !up_if.short_p && !up_if.long_p && !login_i && !tick_i && ce_i
    |=> state_ff == ST_SEL && fred_ff && fleft_ff == FLASH_HALVES &&
    mkind_ff == MEL_FALL)
    else $error("Failed read did not flash red and stay");

  login_refuse_a: assert property (
    state_ff == ST_READ && up_if.long_p && login_i && ce_i
    |=> state_ff == ST_READ && mkind_ff == MEL_FALL && mbusy_ff)
    else $error("Entry not refused under login");

  login_exit_a: assert property (
    state_ff != ST_READ && login_i && ce_i
    |=> state_ff == ST_READ && mkind_ff == MEL_FALL)
    else $error("Login did not end button mode");

  idle_bound_a: assert property (
    state_ff == ST_SEL |-> idle_ff < IDLE_TICKS)
    else $error("Idle timer passed its limit");

  run_bound_a: assert property (
    state_ff == ST_RUN |-> run_ff < RUN_TICKS)
    else $error("Run timer passed its limit");

  beep_force_a: assert property (
    state_ff != ST_READ && ce_i |=> beep_en_o && beep_full_o)
    else $error("Beeper muted in button mode");

  card_save_a: assert property (
    save_req_i && card_present_i && ce_i |=> nvs_wr_o && card_wr_o)
    else $error("Save missed a store");

  ext_load_a: assert property (
    load_req_i && card_present_i && ext_present_i && ce_i
    |=> load_go_o && load_src_o == SRC_EXT)
    else $error("Load did not prefer external module");

  enter_c: cover property (state_ff == ST_READ ##1 state_ff == ST_SEL);
  run_c: cover property (state_ff == ST_SEL ##1 state_ff == ST_RUN);
  wrap_c: cover property (sel_ff == FN_ALIGN ##1 sel_ff == FN_DIAG);
  timeout_c: cover property (state_ff == ST_SEL && !login_i
    && idle_ff == IDLE_TICKS - 16'h1 && tick_i && ce_i);

endmodule

// ==== verilog/bmc_pkg.sv ====
// Constants and types of the button operating mode controller.
// Assumes a slow time-base tick of TICK_MS on a 50 MHz system clock.
//
// Function
// - Upper button held 3 s in reading: halt reading, blank LEDs, enter mode.
// - In button mode every external reading trigger is ignored.
// - In button mode no reading result goes out on the host interface.
// - Successful entry plays a rising melody.
// - Entry preselects reading diagnosis, its LED blinking slowly.
// - Lower button press advances selection without starting, wrapping around.
// - Each lower-button selection step gives one beeper tone.
// - Short upper press on idle function starts it, fast blink, two tones.
// - Short upper press on running function stops it, slow blink, two tones.
// - Learning or setup stops on good read: green flash thrice, rising melody.
// - Learning or setup failing: red flash thrice, falling melody, stay in mode.
// - Upper button held 3 s in mode: back to reading, falling melody, ready on.
// - Entry attempt with software login refused with falling melody.
// - Software login during mode: leave mode, restart reading, falling melody.
// - No start or no activity after function: leave after 30 s, falling melody.
// - Running function ends after 5 min, back to reading, falling melody.
// - In button mode beeper is enabled at full volume, overriding settings.
// - Save writes internal store, and the card when one is present.
// - Card and external module both present: load from external module.
// - Functions are diagnosis, learning, setup, alignment; no user slot.

package bmc_pkg;

  // ************************************************************
  // Time base
  // ************************************************************
  localparam int TICK_MS = 10;
  localparam int DEB_MS = 30;
  localparam int LONG_PRESS_MS = 3000;
  localparam int IDLE_MS = 30000;
  localparam int RUN_LIMIT_MS = 300000;
  localparam int TONE_MS = 100;
  localparam int FLASH_HALF_MS = 250;

  localparam logic [3:0] DEB_TICKS = 4'(DEB_MS / TICK_MS);
  localparam logic [15:0] LONG_TICKS = 16'(LONG_PRESS_MS / TICK_MS);
  localparam logic [15:0] IDLE_TICKS = 16'(IDLE_MS / TICK_MS);
  localparam logic [15:0] RUN_TICKS = 16'(RUN_LIMIT_MS / TICK_MS);
  localparam logic [7:0] TONE_TICKS = 8'(TONE_MS / TICK_MS);
  localparam logic [7:0] FLASH_TICKS = 8'(FLASH_HALF_MS / TICK_MS);

  // Blink rates as tick-counter bit positions
  localparam int FAST_BIT = 3;
  localparam int SLOW_BIT = 5;

  // Ready LED flash: three flashes, six half periods
  localparam logic [2:0] FLASH_HALVES = 3'h6;
  localparam logic [1:0] MEL_LAST_SLOT = 2'h3;

  // ************************************************************
  // Functions offered in button mode
  // ************************************************************
  localparam logic [1:0] FN_DIAG = 2'h0;
  localparam logic [1:0] FN_LEARN = 2'h1;
  localparam logic [1:0] FN_SETUP = 2'h2;
  localparam logic [1:0] FN_ALIGN = 2'h3;

  // Parameter load sources
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_CARD = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;

  typedef enum logic [2:0]
  {
    ST_READ = 3'b001,
    ST_SEL = 3'b010,
    ST_RUN = 3'b100
  } bmc_state_t;

  typedef enum logic [2:0]
  {
    MEL_ONE = 3'h0,
    MEL_TWO = 3'h1,
    MEL_RISE = 3'h2,
    MEL_FALL = 3'h3
  } bmc_mel_t;

endpackage

// ==== verilog/bmc_btn_if.sv ====
// Press events of one debounced button.
// Assumes producer and consumer share one clock.
`timescale 1ns/100ps

interface bmc_btn_if;
  logic press_p;
  logic short_p;
  logic long_p;

  modport src
  (
    output press_p,
    output short_p,
    output long_p
  );

  modport dst
  (
    input press_p,
    input short_p,
    input long_p
  );
endinterface

// ==== verilog/bmc_button.sv ====
// Synchroniser, debouncer and short/long classifier for one button.
// Assumes an active-high asynchronous button level and a one-cycle tick.
`timescale 1ns/100ps

module bmc_button
  import bmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic btn_i,
  bmc_btn_if.src ev
);

  logic sync1_ff, sync2_ff, stable_ff, nxt_stable;
  logic [3:0] deb_ff, nxt_deb;
  logic [15:0] hold_ff, nxt_hold;
  logic long_done_ff, nxt_long_done;
  logic press_ff, short_ff, long_ff;
  logic nxt_press, nxt_short, nxt_long;

  always_comb
  begin
    nxt_stable = stable_ff;
    nxt_deb = 4'h0;
    nxt_hold = hold_ff;
    nxt_long_done = long_done_ff;
    nxt_press = 1'b0;
    nxt_short = 1'b0;
    nxt_long = 1'b0;
    if (sync2_ff != stable_ff)
    begin
      nxt_deb = deb_ff;
      if (tick_i)
      begin
        if (deb_ff == DEB_TICKS - 4'h1)
        begin
          nxt_deb = 4'h0;
          nxt_stable = sync2_ff;
          if (sync2_ff)
          begin
            nxt_press = 1'b1;
            nxt_hold = 16'h0;
            nxt_long_done = 1'b0;
          end
          else
          begin
            nxt_short = !long_done_ff;
          end
        end
        else
        begin
          nxt_deb = deb_ff + 4'h1;
        end
      end
    end
    else if (stable_ff && !long_done_ff && tick_i)
    begin
      if (hold_ff == LONG_TICKS - 16'h1)
      begin
        nxt_long = 1'b1;
        nxt_long_done = 1'b1;
      end
      else
      begin
        nxt_hold = hold_ff + 16'h1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      stable_ff <= 1'b0;
      deb_ff <= 4'h0;
      hold_ff <= 16'h0;
      long_done_ff <= 1'b0;
      press_ff <= 1'b0;
      short_ff <= 1'b0;
      long_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      sync1_ff <= btn_i;
      sync2_ff <= sync1_ff;
      stable_ff <= nxt_stable;
      deb_ff <= nxt_deb;
      hold_ff <= nxt_hold;
      long_done_ff <= nxt_long_done;
      press_ff <= nxt_press;
      short_ff <= nxt_short;
      long_ff <= nxt_long;
    end
  end

  assign ev.press_p = press_ff;
  assign ev.short_p = short_ff;
  assign ev.long_p = long_ff;

endmodule

// ==== dv/bmc_operator.sv ====
// Operator model: one person pressing the two housing buttons.
// Assumes tick_i pulses of the bench time the length of each press.
`timescale 1ns/100ps

module bmc_operator
(
  input wire logic clk_i,
  input wire logic tick_i,
  output logic btn_upper_o,
  output logic btn_lower_o
);
  initial
  begin
    btn_upper_o = 1'b0;
    btn_lower_o = 1'b0;
  end

  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      while (tick_i !== 1'b1)
        @(posedge clk_i);
    end
  endtask

  // Press and hold; up picks the upper button
  task automatic push(input bit up);
    @(posedge clk_i);
    #1;
    if (up)
      btn_upper_o = 1'b1;
    else
      btn_lower_o = 1'b1;
  endtask

  task automatic rel(input bit up);
    @(posedge clk_i);
    #1;
    if (up)
      btn_upper_o = 1'b0;
    else
      btn_lower_o = 1'b0;
  endtask

  task automatic tap(input bit up, input int n);
    push(up);
    ticks(n);
    rel(up);
  endtask
endmodule

// ==== dv/button_mode_controller_tb.sv ====
// Bench of the button mode controller top.
// Assumes bmc_ctrl and the operator model; a tick every second cycle.
`timescale 1ns/100ps

module button_mode_controller_tb;
  import bmc_pkg::*;
  logic clk_i, resetn_i, ce_i, tick_i, login_i, fn_good_i, fn_fail_i;
  logic mute_i, vol_low_i, save_req_i, load_req_i, card_present_i;
  logic ext_present_i, btn_upper_i, btn_lower_i, bq, gq, rq;
  logic btn_mode_o, read_halt_o, trig_en_o, host_out_en_o, status_blank_o;
  logic [3:0] fn_led_o;
  logic [1:0] fn_sel_o, beep_pitch_o, load_src_o;
  logic fn_run_o, ready_grn_o, ready_red_o, beep_o, beep_en_o, beep_full_o;
  logic nvs_wr_o, card_wr_o, load_go_o;
  int fails, comparisons, beeps, grns, reds, c;
  // Columns: save, load, card, ext | nvs, card write, load go, source
  logic [8:0] rows [7] = '{9'h110, 9'h158, 9'h178, 9'h084, 9'h0c5,
    9'h0e6, 9'h0a6};

  bmc_ctrl dut (.clk_i, .resetn_i, .ce_i, .tick_i, .btn_upper_i,
    .btn_lower_i, .login_i, .fn_good_i, .fn_fail_i, .mute_i, .vol_low_i,
    .save_req_i, .load_req_i, .card_present_i, .ext_present_i, .btn_mode_o,
    .read_halt_o, .trig_en_o, .host_out_en_o, .status_blank_o, .fn_led_o,
    .fn_sel_o, .fn_run_o, .ready_grn_o, .ready_red_o, .beep_o,
    .beep_pitch_o, .beep_en_o, .beep_full_o, .nvs_wr_o, .card_wr_o,
    .load_go_o, .load_src_o);

  bmc_operator op (.clk_i, .tick_i, .btn_upper_o(btn_upper_i),
    .btn_lower_o(btn_lower_i));

  // ************************************************************
  // Clock, tick, edge counters and helpers
  // ************************************************************
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) #1 tick_i = ~tick_i;

  // Edge counts taken where the outputs are settled
  always @(negedge clk_i)
  begin
    beeps += (beep_o === 1'b1 && bq !== 1'b1);
    grns += (ready_grn_o === 1'b1 && gq !== 1'b1);
    reds += (ready_red_o === 1'b1 && rq !== 1'b1);
    bq = beep_o;
    gq = ready_grn_o;
    rq = ready_red_o;
  end

  task automatic chk(input string n, input logic [3:0] e,
    input logic [3:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tk(input int n);
    op.ticks(n);
    @(posedge clk_i);
    #1;
  endtask

  task automatic wait_v(input bit k, input logic v, input int lim);
    for (int n = 0; n < lim && (k ? beep_o : btn_mode_o) !== v; n++)
      @(negedge clk_i);
    chk("wait", {3'h0, v}, {3'h0, k ? beep_o : btn_mode_o});
  endtask

  task automatic mel(input bit rise);
    wait_v(1'b1, 1'b1, 800);
    tk(5);
    chk("pitch0", rise ? 4'h0 : 4'h2, beep_pitch_o);
    tk(10);
    chk("pitch1", 4'h1, beep_pitch_o);
    tk(10);
    chk("pitch2", rise ? 4'h2 : 4'h0, beep_pitch_o);
  endtask

  task automatic blinks(input int b, input int n);
    logic p;
    c = 0;
    p = fn_led_o[b];
    repeat (2 * n)
    begin
      @(posedge clk_i);
      #1;
      c += (fn_led_o[b] !== p);
      p = fn_led_o[b];
    end
  endtask

  task automatic long_press(input logic to, input bit rise);
    op.push(1'b1);
    wait_v(1'b0, to, 800);
    mel(rise);
    op.rel(1'b1);
    tk(20);
  endtask

  task automatic press(input bit up);
    op.tap(up, 6);
    tk(8);
  endtask

  task automatic pulse(input bit good);
    @(posedge clk_i);
    #1;
    fn_good_i = good;
    fn_fail_i = !good;
    @(posedge clk_i);
    #1;
    fn_good_i = 1'b0;
    fn_fail_i = 1'b0;
    @(negedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #1800000;
    fails++;
    finish_test;
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial
  begin
    {resetn_i, tick_i, login_i, fn_good_i, fn_fail_i, mute_i} = '0;
    {vol_low_i, save_req_i, load_req_i, card_present_i} = '0;
    ext_present_i = 1'b0;
    ce_i = 1'b1;
    repeat (8) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    @(negedge clk_i);
    chk("reset", 4'hf, {trig_en_o, host_out_en_o, ready_grn_o, beep_en_o});
    chk("reset_mode", 4'h0, {btn_mode_o, read_halt_o, fn_run_o, beep_o});
    $display("test reset done");
    foreach (rows[k])
    begin
      @(posedge clk_i);
      #1;
      {save_req_i, load_req_i, card_present_i, ext_present_i} = rows[k][8:5];
      @(posedge clk_i);
      #1;
      save_req_i = 1'b0;
      load_req_i = 1'b0;
      @(negedge clk_i);
      chk("store", {1'h0, rows[k][4:2]}, {nvs_wr_o, card_wr_o, load_go_o});
      if (rows[k][7])
        chk("src", {2'h0, rows[k][1:0]}, load_src_o);
    end
    $display("test storage done");
    long_press(1'b1, 1'b1);
    chk("halt", 4'h7, {btn_mode_o, read_halt_o, status_blank_o});
    chk("trig", 4'h0, {trig_en_o, host_out_en_o});
    chk("sel", 4'h0, fn_sel_o);
    chk("grn", 4'h0, ready_grn_o);
    blinks(0, 64);
    chk("slow", 4'h2, 4'(c));
    mute_i = 1'b1;
    vol_low_i = 1'b1;
    tk(1);
    chk("vol", 4'h3, {beep_en_o, beep_full_o});
    for (int n = 1; n <= 5; n++)
    begin
      beeps = 0;
      press(1'b0);
      tk(30);
      chk("step", 4'(n % 4), fn_sel_o);
      chk("tone", 4'h1, 4'(beeps));
    end
    beeps = 0;
    op.tap(1'b0, 1);
    tk(10);
    chk("bounce", 4'h1, fn_sel_o);
    chk("bounce_tone", 4'h0, 4'(beeps));
    // Clock enable low: a full press must leave no trace
    ce_i = 1'b0;
    press(1'b0);
    chk("freeze", 4'h1, fn_sel_o);
    ce_i = 1'b1;
    $display("test selection done");
    mute_i = 1'b0;
    press(1'b1);
    chk("start", 4'h1, fn_run_o);
    press(1'b0);
    chk("sel_run", 4'h1, fn_sel_o);
    blinks(1, 64);
    chk("fast", 4'h8, 4'(c));
    chk("two", 4'h2, 4'(beeps));
    grns = 0;
    pulse(1'b1);
    chk("good", 4'h1, {fn_run_o, ready_grn_o});
    mel(1'b1);
    tk(140);
    chk("greens", 4'h3, 4'(grns));
    press(1'b1);
    reds = 0;
    pulse(1'b0);
    mel(1'b0);
    tk(140);
    chk("reds", 4'h3, 4'(reds));
    chk("stay", 4'h1, btn_mode_o);
    press(1'b1);
    tk(50);
    beeps = 0;
    press(1'b1);
    chk("stop", 4'h0, fn_run_o);
    blinks(1, 64);
    chk("slow2", 4'h2, 4'(c));
    chk("two2", 4'h2, 4'(beeps));
    $display("test functions done");
    long_press(1'b0, 1'b0);
    chk("back", 4'h7, {ready_grn_o, trig_en_o, host_out_en_o});
    login_i = 1'b1;
    op.push(1'b1);
    mel(1'b0);
    op.rel(1'b1);
    tk(20);
    chk("refuse", 4'h0, btn_mode_o);
    login_i = 1'b0;
    long_press(1'b1, 1'b1);
    login_i = 1'b1;
    tk(2);
    chk("logout", 4'h1, {btn_mode_o, trig_en_o});
    mel(1'b0);
    login_i = 1'b0;
    $display("test login done");
    long_press(1'b1, 1'b1);
    tk(1500);
    press(1'b0);
    tk(2890);
    chk("idle_hold", 4'h1, btn_mode_o);
    wait_v(1'b0, 1'b0, 400);
    tk(50);
    $display("test idle done");
    long_press(1'b1, 1'b1);
    op.tap(1'b1, 6);
    tk(29850);
    chk("run_hold", 4'h3, {btn_mode_o, fn_run_o});
    wait_v(1'b0, 1'b0, 600);
    mel(1'b0);
    $display("test run limit done");
    finish_test;
  end
endmodule
